// *** hdl/iet_top.sv ***
// interrupt nodes, move channels, external request router and trap entry
`timescale 1ns/10ps
module iet_top #(
  parameter int unsigned AW = 24                                       // move address width
) (
  input  wire logic                                    core_clk_i,     // 250 MHz core clock
  input  wire logic                                    rst_b_i,        // sync reset, active low
  // request sources
  input  wire logic [iet_pkg::NODES-1:0]               src_evt_i,      // dedicated source pulses
  input  wire logic [iet_pkg::SHARED_N-1:0]            alt_evt_i,      // second source of shared nodes
  input  wire logic [iet_pkg::SHARED_N-1:0]            source_select_reg_i, // 1 picks alt source
  // node configuration
  input  wire logic [iet_pkg::NODES-1:0]               node_en_i,      // enable flags
  input  wire logic [iet_pkg::NODES*iet_pkg::PRIO_W-1:0] node_prio_i,  // priority fields
  input  wire logic [iet_pkg::NODES-1:0]               node_move_i,    // 1 routes to a move channel
  input  wire logic [iet_pkg::NODES*3-1:0]             node_chan_i,    // move channel per node
  input  wire logic                                    jump_cache_i,   // jump cache in use
  // move channel load port
  input  wire logic                                    chan_wr_i,      // load strobe
  input  wire logic [2:0]                              chan_sel_i,     // channel to load
  input  wire logic [AW-1:0]                           chan_src_i,     // source pointer
  input  wire logic [AW-1:0]                           chan_dst_i,     // destination pointer
  input  wire logic [iet_pkg::CNT_W-1:0]               chan_cnt_i,     // transfer count
  input  wire logic [3:0]                              chan_mode_i,    // {cont, word, inc_dst, inc_src}
  // external request router
  input  wire logic [iet_pkg::RTR_CH-1:0]              router_in_i,    // trigger input levels
  input  wire logic [iet_pkg::RTR_CH*2-1:0]            edge_sel_i,     // {fall, rise} per input
  input  wire logic [iet_pkg::RTR_CH*iet_pkg::RTR_CH-1:0] route_i,     // input c to unit o: bit o*4+c
  input  wire logic [iet_pkg::RTR_CH*iet_pkg::RTR_CH-1:0] pattern_i,   // pattern mask per unit
  input  wire logic [iet_pkg::RTR_CH*2-1:0]            gate_mode_i,    // gating mode per unit
  // trap
  input  wire logic                                    trap_i,         // trap event pulse
  input  wire logic [3:0]                              trap_num_i,     // trap number
  // cpu side
  output logic                                         intr_req_o,     // service request to cpu
  output logic [6:0]                                   intr_vec_o,     // node index or trap number
  output logic                                         intr_trap_o,    // request is a trap
  input  wire logic                                    intr_ack_i,     // cpu takes the request
  // move stream
  output logic                                         move_valid_o,   // move word valid
  output logic [AW-1:0]                                move_src_o,     // copy from
  output logic [AW-1:0]                                move_dst_o,     // copy to
  output logic                                         move_word_o,    // 1 word, 0 byte
  input  wire logic                                    move_ready_i,   // receiver takes word
  output logic                                         steal_o,        // one stolen cpu cycle
  // status
  output logic [iet_pkg::NODES-1:0]                    node_pend_o,    // request flags
  output logic [iet_pkg::RTR_CH-1:0]                   router_out_o    // gated router events
);

  localparam int unsigned N  = iet_pkg::NODES;
  localparam int unsigned MW = 2 * AW + 1;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [N-1:0]                 flag_q;

  logic [iet_pkg::RTR_CH-1:0]   in_prev_q;
  logic [iet_pkg::RTR_CH-1:0]   det;
  logic [iet_pkg::RTR_CH-1:0]   gated;
  logic [N-1:0]                 node_evt;

  logic [AW-1:0]                src_q [iet_pkg::CHANS];
  logic [AW-1:0]                dst_q [iet_pkg::CHANS];
  logic [iet_pkg::CNT_W-1:0]    cnt_q [iet_pkg::CHANS];
  logic [3:0]                   mode_q [iet_pkg::CHANS];

  iet_pkg::iet_state_e          state_q;
  logic [3:0]                   wait_q;
  logic                         trap_pend_q;
  logic [3:0]                   trap_num_q;

  logic                         win_v;
  logic [6:0]                   win_idx;
  logic [iet_pkg::PRIO_W-1:0]   win_p;
  logic [2:0]                   win_ch;
  logic                         win_move;
  logic                         win_intr;

  logic                         push;
  logic                         buf_ready;
  logic [MW-1:0]                push_data;
  logic                         cnt_hits_zero;

  logic                         skid_v_q;
  logic [MW-1:0]                skid_q;
  logic [MW-1:0]                out_q;
  logic                         trap_go;
  logic                         intr_go;

  // ---------------------------------------------------------------
  // external request router
  // ---------------------------------------------------------------
  // edge detection against the previous level
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      in_prev_q <= '0;
    end else begin
      in_prev_q <= router_in_i;
    end
  end

  // one pulse per chosen edge
  always_comb begin
    for (int c = 0; c < int'(iet_pkg::RTR_CH); c++) begin
      det[c] = (edge_sel_i[2*c]   &  router_in_i[c] & ~in_prev_q[c])
             | (edge_sel_i[2*c+1] & ~router_in_i[c] &  in_prev_q[c]);
    end
  end

  // gating: matrix combine, then pattern filter on the input levels
  always_comb begin
    for (int o = 0; o < int'(iet_pkg::RTR_CH); o++) begin
      logic hit;
      logic match;
      hit   = |(det & route_i[o*4 +: 4]);
      match = ((router_in_i & pattern_i[o*4 +: 4]) == pattern_i[o*4 +: 4]);
      case (gate_mode_i[o*2 +: 2])
        iet_pkg::GATE_ALL:   gated[o] = hit;
        iet_pkg::GATE_MATCH: gated[o] = hit & match;
        iet_pkg::GATE_MISS:  gated[o] = hit & ~match;
        default:             gated[o] = 1'b0;
      endcase
    end
  end

  // registered copy for observation
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      router_out_o <= '0;
    end else begin
      router_out_o <= gated;
    end
  end

  // ---------------------------------------------------------------
  // node events and source selection
  // ---------------------------------------------------------------
  // router ors into nodes 0..3
  always_comb begin
    node_evt = src_evt_i;
    for (int o = 0; o < int'(iet_pkg::RTR_CH); o++) begin
      node_evt[iet_pkg::RTR_NODE0 + o] = src_evt_i[iet_pkg::RTR_NODE0 + o] | gated[o];
    end
    for (int s = 0; s < int'(iet_pkg::SHARED_N); s++) begin
      node_evt[iet_pkg::SHARED_BASE + s] = source_select_reg_i[s] ? alt_evt_i[s]
                                                                  : src_evt_i[iet_pkg::SHARED_BASE + s];
    end
  end

  // ---------------------------------------------------------------
  // arbitration over enabled pending nodes
  // ---------------------------------------------------------------
  // strict greater keeps the lowest index on a tie; a long serial compare chain, one stage per node
  always_comb begin
    win_v   = 1'b0;
    win_idx = '0;
    win_p   = '0;
    for (int i = 0; i < int'(N); i++) begin
      if (flag_q[i] && node_en_i[i] &&
          (!win_v || node_prio_i[i*iet_pkg::PRIO_W +: iet_pkg::PRIO_W] > win_p)) begin
        win_v   = 1'b1;
        win_idx = 7'(i);
        win_p   = node_prio_i[i*iet_pkg::PRIO_W +: iet_pkg::PRIO_W];
      end
    end
  end

  // a drained channel falls back to the vectored path so the end interrupt is served
  assign win_ch        = node_chan_i[win_idx*3 +: 3];
  assign win_move      = win_v && node_move_i[win_idx] &&
                         (mode_q[win_ch][3] || cnt_q[win_ch] != '0);
  assign trap_go       = (state_q == iet_pkg::ST_IDLE) && trap_pend_q;
  assign push          = (state_q == iet_pkg::ST_IDLE) && !trap_pend_q && win_move && buf_ready;
  assign win_intr      = win_v && !win_move;
  assign intr_go       = (state_q == iet_pkg::ST_IDLE) && !trap_pend_q && win_intr;
  assign cnt_hits_zero = !mode_q[win_ch][3] && cnt_q[win_ch] == iet_pkg::CNT_W'(1);
  assign push_data     = {mode_q[win_ch][2], src_q[win_ch], dst_q[win_ch]};

  // ---------------------------------------------------------------
  // request flags
  // ---------------------------------------------------------------
  // an event in the clearing cycle wins; a move that empties its counter re-arms the flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      flag_q <= '0;
    end else begin
      for (int i = 0; i < int'(N); i++) begin
        if (node_evt[i]) begin
          flag_q[i] <= 1'b1;
        end else if (push && win_idx == 7'(i)) begin
          flag_q[i] <= cnt_hits_zero;
        end else if (intr_go && win_idx == 7'(i)) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  assign node_pend_o = flag_q;

  // ---------------------------------------------------------------
  // move channels
  // ---------------------------------------------------------------
  // a move beats a load
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      for (int c = 0; c < int'(iet_pkg::CHANS); c++) begin
        src_q[c]  <= '0;
        dst_q[c]  <= '0;
        cnt_q[c]  <= iet_pkg::CNT_RST;
        mode_q[c] <= '0;
      end
    end else if (push) begin
      if (mode_q[win_ch][0]) begin
        src_q[win_ch] <= src_q[win_ch] + (mode_q[win_ch][2] ? AW'(2) : AW'(1));
      end
      if (mode_q[win_ch][1]) begin
        dst_q[win_ch] <= dst_q[win_ch] + (mode_q[win_ch][2] ? AW'(2) : AW'(1));
      end
      if (!mode_q[win_ch][3]) begin
        cnt_q[win_ch] <= cnt_q[win_ch] - iet_pkg::CNT_W'(1);
      end
    end else if (chan_wr_i) begin
      src_q[chan_sel_i]  <= chan_src_i;
      dst_q[chan_sel_i]  <= chan_dst_i;
      cnt_q[chan_sel_i]  <= chan_cnt_i;
      mode_q[chan_sel_i] <= chan_mode_i;
    end
  end

  // one stolen cycle per move, no routine entered
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      steal_o <= 1'b0;
    end else begin
      steal_o <= push;
    end
  end

  // ---------------------------------------------------------------
  // two-entry move buffer
  // ---------------------------------------------------------------
  // output stage plus skid stage; outputs stay on flops and a receiver stall drops nothing
  assign buf_ready = !skid_v_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      move_valid_o <= 1'b0;
      skid_v_q     <= 1'b0;
      out_q        <= '0;
      skid_q       <= '0;
    end else begin
      if (!move_valid_o || move_ready_i) begin
        if (skid_v_q) begin
          out_q        <= skid_q;
          move_valid_o <= 1'b1;
          skid_v_q     <= push;
          skid_q       <= push_data;
        end else begin
          out_q        <= push_data;
          move_valid_o <= push;
        end
      end else if (push) begin
        skid_v_q <= 1'b1;
        skid_q   <= push_data;
      end
    end
  end

  assign move_word_o = out_q[MW-1];
  assign move_src_o  = out_q[2*AW-1:AW];
  assign move_dst_o  = out_q[AW-1:0];

  // ---------------------------------------------------------------
  // trap capture
  // ---------------------------------------------------------------
  // a new trap beats the clear
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      trap_pend_q <= 1'b0;
      trap_num_q  <= '0;
    end else if (trap_i) begin
      trap_pend_q <= 1'b1;
      trap_num_q  <= trap_num_i;
    end else if (trap_go) begin
      trap_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // cpu request sequencer
  // ---------------------------------------------------------------
  // traps skip the response wait; a trap arriving mid-wait is served after the current one
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      state_q     <= iet_pkg::ST_IDLE;
      wait_q      <= '0;
      intr_req_o  <= 1'b0;
      intr_vec_o  <= '0;
      intr_trap_o <= 1'b0;
    end else begin
      case (state_q)
        iet_pkg::ST_IDLE: begin
          if (trap_go) begin
            intr_req_o  <= 1'b1;
            intr_trap_o <= 1'b1;
            intr_vec_o  <= {3'h0, trap_num_q};
            state_q     <= iet_pkg::ST_CPU;
          end else if (intr_go) begin
            intr_vec_o  <= win_idx;
            intr_trap_o <= 1'b0;
            wait_q      <= (jump_cache_i ? iet_pkg::LAT_JC : iet_pkg::LAT_NC) - 4'h3;
            state_q     <= iet_pkg::ST_WAIT;
          end
        end
        iet_pkg::ST_WAIT: begin
          if (wait_q == 4'h0) begin
            intr_req_o <= 1'b1;
            state_q    <= iet_pkg::ST_CPU;
          end else begin
            wait_q <= wait_q - 4'h1;
          end
        end
        iet_pkg::ST_CPU: begin
          if (intr_ack_i) begin
            intr_req_o <= 1'b0;
            state_q    <= iet_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q    <= iet_pkg::ST_IDLE;
          intr_req_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// *** hdl/iet_pkg.sv ***
// constants and types shared by the interrupt and event transfer unit
//
// Function
// - each request node is steered by configuration to a vectored interrupt or to one move channel.
// - a vectored service stops the program and branches to the vector of the requesting node.
// - a move-channel service takes one cycle and enters no service routine.
// - a move copies one byte or word and then steps the source, the destination or both pointers.
// - every move decrements the channel counter except in continuous mode, where it stays.
// - when a channel counter reaches zero a vectored interrupt of the same node follows.
// - there are eight independent move channels.
// - a request reaches its vectored service after 7 clocks with the jump cache, 11 without.
// - there are 112 request nodes, each with request flag, enable flag and priority field.
// - source-select bits choose which source drives each shared node.
// - the external request router has 4 trigger inputs, a routing matrix and 4 gating units.
// - each router input detects rising, falling or both edges as configured.
// - each gating unit combines its routed events and passes them on pattern match or miss.
// - a hardware trap gets an immediate reaction that looks like a vectored interrupt.
package iet_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int unsigned NODES    = 112;
  localparam int unsigned CHANS    = 8;
  localparam int unsigned RTR_CH   = 4;
  localparam int unsigned PRIO_W   = 4;
  localparam int unsigned CNT_W    = 8;
  localparam int unsigned SHARED_N = 8;

  // ---------------------------------------------------------------
  // node placement
  // ---------------------------------------------------------------
  localparam int unsigned RTR_NODE0   = 0;   // router outputs feed nodes 0..3
  localparam int unsigned SHARED_BASE = 104; // nodes 104..111 are shared

  // ---------------------------------------------------------------
  // timing: response in cpu clocks, one core clock each
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ    = 250;
  localparam int unsigned LAT_JC_CLK = 7;
  localparam int unsigned LAT_NC_CLK = 11;
  localparam logic [3:0]  LAT_JC     = 4'(LAT_JC_CLK);
  localparam logic [3:0]  LAT_NC     = 4'(LAT_NC_CLK);

  // ---------------------------------------------------------------
  // gating modes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] GATE_OFF   = 2'h0;
  localparam logic [1:0] GATE_ALL   = 2'h1;
  localparam logic [1:0] GATE_MATCH = 2'h2;
  localparam logic [1:0] GATE_MISS  = 2'h3;
  localparam logic [7:0] CNT_RST    = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CPU  = 2'b10
  } iet_state_e;

endpackage

// *** tb/iet_asserts.sv ***
// concurrent checks on the ports of the interrupt and event transfer unit
`timescale 1ns/10ps
module iet_asserts #(
  parameter int unsigned AW = 24                            // move address width
) (
  input wire logic                         core_clk_i,     // core clock
  input wire logic                         rst_b_i,        // sync reset, active low
  input wire logic [iet_pkg::NODES-1:0]    src_evt_i,      // source pulses
  input wire logic [iet_pkg::NODES-1:0]    node_en_i,      // enable flags
  input wire logic                         jump_cache_i,   // jump cache in use
  input wire logic [iet_pkg::RTR_CH*2-1:0] gate_mode_i,    // gating modes
  input wire logic                         intr_req_o,     // cpu request
  input wire logic [6:0]                   intr_vec_o,     // vector
  input wire logic                         intr_trap_o,    // trap marker
  input wire logic                         intr_ack_i,     // cpu ack
  input wire logic                         move_valid_o,   // move valid
  input wire logic [AW-1:0]                move_src_o,     // copy from
  input wire logic [AW-1:0]                move_dst_o,     // copy to
  input wire logic                         move_ready_i,   // receiver ready
  input wire logic                         steal_o,        // stolen cycle
  input wire logic [iet_pkg::NODES-1:0]    node_pend_o,    // request flags
  input wire logic [iet_pkg::RTR_CH-1:0]   router_out_o    // gated events
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic [iet_pkg::NODES-1:0] pend_h [10];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // flag history, so a response can be tied to the cycle its flag fell
  always_ff @(posedge core_clk_i) begin
    pend_h[0] <= node_pend_o;
    for (int k = 1; k < 10; k++) pend_h[k] <= pend_h[k-1];
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_req_hold: assert property (intr_req_o && !intr_ack_i |=> intr_req_o && $stable(intr_vec_o)
    && $stable(intr_trap_o)) else $error("request left or changed before ack");
  a_req_drop: assert property (intr_req_o && intr_ack_i |=> !intr_req_o)
    else $error("request kept after ack");
  a_lat_jc: assert property ($rose(intr_req_o) && !intr_trap_o && jump_cache_i |->
    pend_h[5][intr_vec_o] && !pend_h[4][intr_vec_o]) else $error("response time wrong with jump cache");
  a_lat_nc: assert property ($rose(intr_req_o) && !intr_trap_o && !jump_cache_i |->
    pend_h[9][intr_vec_o] && !pend_h[8][intr_vec_o]) else $error("response time wrong without jump cache");
  a_move_hold: assert property (move_valid_o && !move_ready_i |=> move_valid_o
    && $stable(move_src_o) && $stable(move_dst_o)) else $error("move word lost while stalled");
  a_steal_valid: assert property (steal_o |-> move_valid_o) else $error("steal without move");
  a_steal_cause: assert property (steal_o |-> $past(|node_pend_o))
    else $error("move without pending flag");
  a_flag_set: assert property (1'b1 |=> (node_pend_o[103:0] & $past(src_evt_i[103:0]))
    == $past(src_evt_i[103:0])) else $error("source event did not set flag");
  a_en_only: assert property (intr_req_o && !intr_trap_o |-> node_en_i[intr_vec_o])
    else $error("disabled node serviced");
  a_gate_off: assert property (router_out_o[2] |-> $past(gate_mode_i[5:4]) != iet_pkg::GATE_OFF)
    else $error("event passed a gate that is off");
endmodule
bind iet_top iet_asserts #(.AW(AW)) iet_asserts_inst (.core_clk_i, .rst_b_i, .src_evt_i, .node_en_i,
  .jump_cache_i, .gate_mode_i, .intr_req_o, .intr_vec_o, .intr_trap_o, .intr_ack_i, .move_valid_o,
  .move_src_o, .move_dst_o, .move_ready_i, .steal_o, .node_pend_o, .router_out_o);

// *** tb/iet_cpu_model.sv ***
// cpu core and move receiver standing at the far side of the unit
`timescale 1ns/10ps
module iet_cpu_model #(
  parameter int unsigned AW = 24            // address width
) (
  input  wire logic          core_clk_i,   // core clock
  input  wire logic          rst_b_i,      // sync reset, active low
  input  wire logic          intr_req_i,   // service request
  output logic               intr_ack_o,   // one-cycle ack
  input  wire logic          move_valid_i, // move valid
  input  wire logic [AW-1:0] move_src_i,   // copy from
  input  wire logic [AW-1:0] move_dst_i,   // copy to
  input  wire logic          move_word_i,  // word size
  output logic               move_ready_o, // accept
  input  wire logic          stall_i       // receiver busy
);
  logic [1:0]    wait_q;
  logic [2*AW:0] got[$];

  // ack after a short think time so the request has to stand
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      wait_q     <= 2'h0;
      intr_ack_o <= 1'b0;
    end else begin
      intr_ack_o <= 1'b0;
      if (intr_req_i && !intr_ack_o) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q == 2'h2) begin
          intr_ack_o <= 1'b1;
          wait_q     <= 2'h0;
        end
      end
    end
  end

  // receiver takes a word whenever the bench does not stall it
  assign move_ready_o = !stall_i;
  always @(posedge core_clk_i) begin
    if (rst_b_i && move_valid_i && move_ready_o) got.push_back({move_word_i, move_src_i, move_dst_i});
  end
endmodule

// *** tb/iet_tb_top.sv ***
// self-checking bench for the interrupt and event transfer unit
`timescale 1ns/10ps
module iet_tb_top;
  logic         clk, rst_b, jc, cw, trap, ack, req, tflag, mvalid, mword, mready, steal, stall;
  logic [111:0] src, en, mv, pend;
  logic [447:0] prio;
  logic [335:0] chan;
  logic [7:0]   alt, ssel, esel, gmode, ccnt;
  logic [15:0]  route, pat;
  logic [3:0]   rin, tnum, cmode, rout;
  logic [2:0]   csel;
  logic [23:0]  csrc, cdst, msrc, mdst;
  logic [6:0]   vec;
  int           fails, tests_run, steals, rpulse;

  iet_top iet_top_inst (.core_clk_i(clk), .rst_b_i(rst_b), .src_evt_i(src), .alt_evt_i(alt),
    .source_select_reg_i(ssel), .node_en_i(en), .node_prio_i(prio), .node_move_i(mv), .node_chan_i(chan),
    .jump_cache_i(jc), .chan_wr_i(cw), .chan_sel_i(csel), .chan_src_i(csrc), .chan_dst_i(cdst),
    .chan_cnt_i(ccnt), .chan_mode_i(cmode), .router_in_i(rin), .edge_sel_i(esel), .route_i(route),
    .pattern_i(pat), .gate_mode_i(gmode), .trap_i(trap), .trap_num_i(tnum), .intr_req_o(req),
    .intr_vec_o(vec), .intr_trap_o(tflag), .intr_ack_i(ack), .move_valid_o(mvalid), .move_src_o(msrc),
    .move_dst_o(mdst), .move_word_o(mword), .move_ready_i(mready), .steal_o(steal),
    .node_pend_o(pend), .router_out_o(rout));
  iet_cpu_model iet_cpu_model_inst (.core_clk_i(clk), .rst_b_i(rst_b), .intr_req_i(req), .intr_ack_o(ack),
    .move_valid_i(mvalid), .move_src_i(msrc), .move_dst_i(mdst), .move_word_i(mword),
    .move_ready_o(mready), .stall_i(stall));

  // clock and pulse counters
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (steal === 1'b1) steals++;
    if (rout[2] === 1'b1) rpulse++;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one-cycle source pulse; returns at the edge that takes it
  task automatic pulse(input int i);
    @(posedge clk);
    src[i] <= 1'b1;
    @(posedge clk);
    src[i] <= 1'b0;
  endtask
  // wait for the request, judge it, let the model ack it
  task automatic serve(input logic [6:0] v, input logic t, input int lat);
    int n;
    n = 0;
    while (req !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(64'(req), 64'h1);
    if (lat > 0) check(64'(n + 1), 64'(lat));
    check(64'(vec), 64'(v));
    check(64'(tflag), 64'(t));
    for (int k = 0; k < 20 && req === 1'b1; k++) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic load(input logic [2:0] c, input logic [23:0] s, input logic [23:0] d,
                      input logic [7:0] n, input logic [3:0] m);
    @(posedge clk);
    cw    <= 1'b1;
    csel  <= c;
    csrc  <= s;
    cdst  <= d;
    ccnt  <= n;
    cmode <= m;
    @(posedge clk);
    cw    <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_latency();
    for (int j = 0; j < 2; j++) begin
      jc     <= 1'(j == 0);
      en[20] <= 1'b1;
      pulse(20);
      serve(7'h14, 1'b0, (j == 0) ? iet_pkg::LAT_JC_CLK : iet_pkg::LAT_NC_CLK);
    end
  endtask
  // three at once: highest value first, the disabled one never served
  task automatic t_prio();
    jc            <= 1'b1;
    prio[4*30+:4] <= 4'h2;
    prio[4*31+:4] <= 4'h9;
    prio[4*32+:4] <= 4'hf;
    en[31:30]     <= 2'h3;
    @(posedge clk);
    src[32:30]    <= 3'h7;
    @(posedge clk);
    src[32:30]    <= 3'h0;
    serve(7'h1f, 1'b0, 7);
    serve(7'h1e, 1'b0, 0);
    check(64'(pend[32:30]), 64'h4);
  endtask
  task automatic t_trap();
    en[40]  <= 1'b1;
    @(posedge clk);
    src[40] <= 1'b1;
    trap    <= 1'b1;
    tnum    <= 4'h9;
    @(posedge clk);
    src[40] <= 1'b0;
    trap    <= 1'b0;
    serve(7'h09, 1'b1, 2);
    serve(7'h28, 1'b0, 0);
  endtask
  // counted block ends in an interrupt; continuous block fills the buffer
  task automatic t_move();
    int b;
    load(3'h3, 24'h000100, 24'h000200, 8'h02, 4'h5);
    en[50]        <= 1'b1;
    mv[50]        <= 1'b1;
    chan[3*50+:3] <= 3'h3;
    stall         <= 1'b1;
    b = steals;
    pulse(50);
    pulse(50);
    tick(3);
    check(64'(steals - b), 64'h2);
    stall <= 1'b0;
    serve(7'h32, 1'b0, 0);
    check(64'(iet_cpu_model_inst.got[0]), 64'h1000100000200);
    check(64'(iet_cpu_model_inst.got[1]), 64'h1000102000200);
    pulse(50);
    serve(7'h32, 1'b0, 7);
    check(64'(steals - b), 64'h2);
    load(3'h4, 24'h000300, 24'h000400, 8'h01, 4'hb);
    en[51]        <= 1'b1;
    mv[51]        <= 1'b1;
    chan[3*51+:3] <= 3'h4;
    stall         <= 1'b1;
    b = steals;
    repeat (3) pulse(51);
    tick(3);
    check(64'(steals - b), 64'h2);
    check(64'(pend[51]), 64'h1);
    stall <= 1'b0;
    tick(6);
    check(64'(steals - b), 64'h3);
    check(64'(req), 64'h0);
    for (int k = 0; k < 3; k++) begin
      check(64'(iet_cpu_model_inst.got[2+k]), 64'({1'b0, 24'h300 + 24'(k), 24'h400 + 24'(k)}));
    end
  endtask
  // table of {edge select, gate mode} against pulses per up-down toggle
  task automatic t_router();
    logic [3:0] tab [6] = '{4'h5, 4'h9, 4'hd, 4'he, 4'hf, 4'hc};
    int         ex [6]  = '{1, 1, 2, 0, 2, 0};
    int         b;
    route[10] <= 1'b1;
    pat[11:8] <= 4'h2;
    for (int k = 0; k < 6; k++) begin
      esel[5:4]  <= tab[k][3:2];
      gmode[5:4] <= tab[k][1:0];
      tick(3);
      b = rpulse;
      rin[2] <= 1'b1;
      tick(4);
      rin[2] <= 1'b0;
      tick(4);
      check(64'(rpulse - b), 64'(ex[k]));
    end
    check(64'(pend[2]), 64'h1);
  endtask
  task automatic t_shared();
    ssel[0] <= 1'b1;
    pulse(104);
    tick(2);
    check(64'(pend[104]), 64'h0);
    alt[0] <= 1'b1;
    @(posedge clk);
    alt[0] <= 1'b0;
    tick(2);
    check(64'(pend[104]), 64'h1);
  endtask

  // hang guard, far beyond the scenarios' needs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    {src, en, mv, prio, chan, alt, ssel, esel, gmode, ccnt, route, pat, rin, tnum, cmode, csel, csrc, cdst} = '0;
    {jc, cw, trap, stall} = '0;
    rst_b = 1'b0;
    tick(16);
    rst_b <= 1'b1;
    tick(1);
    t_latency();
    t_prio();
    t_trap();
    t_move();
    t_router();
    t_shared();
    results();
  end
endmodule
